//--- src/sgm_top.sv
// state-of-charge gauge, current conditioning and remappable pin functions
`timescale 1ns/1ps
`default_nettype none
module sgm_top #(
  parameter int unsigned GATE_CYC = sgm_pkg::GATE_CYC, // frequency gate in cycles
  parameter logic [15:0] LO_LIMIT = sgm_pkg::LO_LIMIT_RST // low range limit
) (
  input wire logic clk_i, // 20 MHz clock
  input wire logic srst_i, // synchronous reset, high
  input wire logic [7:0] avs_address_i, // byte address
  input wire logic avs_read_i, // read request
  input wire logic avs_write_i, // write request
  input wire logic [3:0] avs_byteenable_i, // byte lanes
  input wire logic [31:0] avs_writedata_i, // write data
  output logic [31:0] avs_readdata_o, // read data
  output logic avs_waitrequest_o, // stall
  input wire sgm_pkg::sgm_sensor_t sens_i, // converted sensor sample
  input wire logic [sgm_pkg::NPIN-1:0] pad_in_i, // pin levels
  output logic [sgm_pkg::NPIN-1:0] pad_out_o, // pin drive level
  output logic [sgm_pkg::NPIN-1:0] pad_oe_n_o // pin enable, low drives
);
  import sgm_pkg::*;

  logic [31:0] wmask, mdata;
  logic wr_fire, wr_ctrl;
  logic [6:0] soc, stored_soc, dmin, dmax, duty;
  logic [15:0] cal_lo, cal_hi, deadzone;
  logic signed [15:0] offset, current;
  logic reverse, reject;
  sgm_func_t func [NPIN];
  logic [NPIN-1:0] sync1, sync2;
  logic [15:0] pulse_cnt, win_edges, pulse_freq;
  logic [31:0] gate_cnt;
  logic speed_prev, pwm_q, cs_on;
  logic [15:0] pwm_div;
  logic [6:0] pwm_step;
  logic [31:0] rd_mux;

  assign wmask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                  {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
  assign mdata = avs_writedata_i & wmask;
  // a write lands only on the edge where the master sees waitrequest low
  assign wr_fire = avs_write_i & ~avs_waitrequest_o;
  assign wr_ctrl = wr_fire & (avs_address_i == OFS_CTRL);

  function automatic logic [6:0] pct(input logic [7:0] v);
    pct = (v > {1'b0, PCT_FULL}) ? PCT_FULL : v[6:0];
  endfunction

  // one wait state per transfer keeps read data registered
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      avs_waitrequest_o <= 1'b1;
    else if ((avs_read_i | avs_write_i) & avs_waitrequest_o)
      avs_waitrequest_o <= 1'b0;
    else
      avs_waitrequest_o <= 1'b1;
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      avs_readdata_o <= 32'h0000_0000;
    else if (avs_read_i & avs_waitrequest_o)
      avs_readdata_o <= rd_mux;
  end

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (avs_address_i)
      OFS_CTRL: rd_mux = {23'h0, reject, 7'h0, reverse};
      OFS_SOC: rd_mux = {25'h0, soc};
      OFS_CAL_LO: rd_mux = {16'h0, cal_lo};
      OFS_CAL_HI: rd_mux = {16'h0, cal_hi};
      OFS_DEADZONE: rd_mux = {16'h0, deadzone};
      OFS_DUTY_CFG: rd_mux = {17'h0, dmax, 1'b0, dmin};
      OFS_STORED_SOC: rd_mux = {25'h0, stored_soc};
      OFS_CURRENT: rd_mux = {{16{current[15]}}, current};
      OFS_PULSE_CNT: rd_mux = {16'h0, pulse_cnt};
      OFS_PULSE_FREQ: rd_mux = {16'h0, pulse_freq};
      OFS_PIN_LEVEL: rd_mux = {18'h0, sync2};
      OFS_DUTY_NOW: rd_mux = {25'h0, duty};
      default:
      begin
        for (int i = 0; i < NPIN; i++)
          if (avs_address_i == OFS_PIN_FUNC + 8'(4 * i))
            rd_mux = {29'h0, func[i]};
      end
    endcase
  end

  // configuration registers
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      cal_lo <= CAL_RST;
      cal_hi <= CAL_RST;
      deadzone <= DEADZONE_RST;
      dmin <= DUTY_MIN_RST;
      dmax <= DUTY_MAX_RST;
      stored_soc <= SOC_RST;
      reverse <= 1'b0;
    end
    else if (wr_fire)
    begin
      case (avs_address_i)
        OFS_CAL_LO: cal_lo <= (cal_lo & ~wmask[15:0]) | mdata[15:0];
        OFS_CAL_HI: cal_hi <= (cal_hi & ~wmask[15:0]) | mdata[15:0];
        OFS_DEADZONE: deadzone <= (deadzone & ~wmask[15:0]) | mdata[15:0];
        OFS_DUTY_CFG:
        begin
          dmin <= pct(({1'b0, dmin} & ~wmask[7:0]) | mdata[7:0]);
          dmax <= pct(({1'b0, dmax} & ~wmask[15:8]) | mdata[15:8]);
        end
        OFS_STORED_SOC: stored_soc <= pct(({1'b0, stored_soc} & ~wmask[7:0]) | mdata[7:0]);
        OFS_CTRL: reverse <= avs_byteenable_i[0] ? avs_writedata_i[CTRL_REVERSE] : reverse;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      soc <= SOC_RST;
    else if (wr_ctrl & mdata[CTRL_LOAD])
      soc <= stored_soc;
    else if (wr_fire & (avs_address_i == OFS_SOC) & avs_byteenable_i[0])
      soc <= pct(avs_writedata_i[7:0]);
  end

  a_soc_reset: assert property (@(posedge clk_i) disable iff (srst_i) $fell(srst_i) |-> soc == SOC_RST)
    else $error("charge not zero after reset");
  a_soc_write: assert property (@(posedge clk_i) disable iff (srst_i)
    wr_fire && avs_address_i == OFS_SOC && avs_byteenable_i[0] |=> soc == pct($past(avs_writedata_i[7:0])))
    else $error("written charge not held");
  a_cfg_load: assert property (@(posedge clk_i) disable iff (srst_i)
    wr_ctrl && mdata[CTRL_LOAD] |=> soc == $past(stored_soc))
    else $error("stored charge not applied");

  // current path; the range switch keeps resolution near zero
  logic [15:0] mag_lo, dmag;
  logic sel_hi, in_dz;
  logic signed [15:0] raw, scaled, diff, dir;
  logic signed [32:0] prod;
  assign mag_lo = sens_i.lo[15] ? 16'(-sens_i.lo) : sens_i.lo;
  assign sel_hi = mag_lo > LO_LIMIT;
  assign raw = sel_hi ? sens_i.hi : sens_i.lo;
  assign prod = raw * $signed({1'b0, sel_hi ? cal_hi : cal_lo});
  assign scaled = prod[GAIN_SHIFT +: 16];
  assign diff = 16'(scaled - offset);
  assign dmag = diff[15] ? 16'(-diff) : diff;
  assign in_dz = dmag <= deadzone;
  assign dir = reverse ? 16'(-diff) : diff;
  assign cs_on = (func[PIN_INPUT0] == FN_CSENSE);

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      offset <= 16'sh0000;
    else if (wr_ctrl & mdata[CTRL_ZERO])
      offset <= scaled;
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i | ~cs_on)
      current <= 16'sh0000;
    else if (sens_i.valid)
      current <= in_dz ? 16'sh0000 : dir;
  end

  a_zero_cmd: assert property (@(posedge clk_i) disable iff (srst_i)
    wr_ctrl && mdata[CTRL_ZERO] |=> offset == $past(scaled))
    else $error("offset not captured");
  a_dead_zone: assert property (@(posedge clk_i) disable iff (srst_i)
    cs_on && sens_i.valid && in_dz |=> current == 16'sh0000)
    else $error("deadzone reading not zero");
  a_reverse_sign: assert property (@(posedge clk_i) disable iff (srst_i)
    cs_on && sens_i.valid && !in_dz && reverse |=> current == 16'(-$past(diff)))
    else $error("reverse sign wrong");

  logic signed [8:0] span;
  logic signed [16:0] prod_d, quot;
  logic signed [9:0] next_duty;
  assign span = $signed({2'b0, dmax}) - $signed({2'b0, dmin});
  assign prod_d = span * $signed({1'b0, soc});
  assign quot = prod_d / $signed({10'h0, PCT_FULL});
  assign next_duty = $signed({3'b0, dmin}) + quot[9:0];

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      duty <= DUTY_MIN_RST;
    else
      duty <= next_duty[6:0];
  end

  a_duty_min: assert property (@(posedge clk_i) disable iff (srst_i) soc == SOC_RST |=> duty == $past(dmin))
    else $error("duty not minimum at empty");
  a_duty_range: assert property (@(posedge clk_i) disable iff (srst_i)
    $past(srst_i) == 1'b0 |->
      ((duty >= $past(dmin) && duty <= $past(dmax)) || (duty <= $past(dmin) && duty >= $past(dmax)))
      && ($past(soc) != PCT_FULL || duty == $past(dmax)))
    else $error("duty outside range");

  // gauge PWM, 100 steps per period
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      pwm_div <= 16'h0000;
      pwm_step <= 7'h00;
      pwm_q <= 1'b0;
    end
    else
    begin
      pwm_q <= pwm_step < duty;
      if (pwm_div == 16'(PWM_DIV - 1))
      begin
        pwm_div <= 16'h0000;
        pwm_step <= (pwm_step == 7'(PWM_STEPS - 1)) ? 7'h00 : pwm_step + 7'h01;
      end
      else
        pwm_div <= pwm_div + 16'h0001;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      sync1 <= '0;
      sync2 <= '0;
    end
    else
    begin
      sync1 <= pad_in_i;
      sync2 <= sync1;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i | (func[PIN_SPEED] != FN_PULSE))
    begin
      speed_prev <= 1'b0;
      pulse_cnt <= 16'h0000;
      win_edges <= 16'h0000;
      pulse_freq <= 16'h0000;
      gate_cnt <= 32'h0000_0000;
    end
    else
    begin
      speed_prev <= sync2[PIN_SPEED];
      if (sync2[PIN_SPEED] & ~speed_prev)
        pulse_cnt <= pulse_cnt + 16'h0001;
      if (gate_cnt == GATE_CYC - 1)
      begin
        gate_cnt <= 32'h0000_0000;
        pulse_freq <= win_edges + 16'(sync2[PIN_SPEED] & ~speed_prev);
        win_edges <= 16'h0000;
      end
      else
      begin
        gate_cnt <= gate_cnt + 32'h0000_0001;
        win_edges <= win_edges + 16'(sync2[PIN_SPEED] & ~speed_prev);
      end
    end
  end

  // pin function assignment
  logic [3:0] fidx;
  logic fsel, od_pin, is_in, legal, in_grp;
  sgm_func_t fcode;
  assign fidx = 4'((avs_address_i - OFS_PIN_FUNC) >> 2);
  assign fsel = wr_fire & avs_byteenable_i[0] & (avs_address_i >= OFS_PIN_FUNC) & (avs_address_i[1:0] == 2'h0)
                & (avs_address_i < OFS_PIN_FUNC + 8'(4 * NPIN));
  assign fcode = sgm_func_t'(avs_writedata_i[2:0]);
  assign od_pin = fidx <= 4'(PIN_CHARGER);
  assign in_grp = fidx >= 4'(PIN_INPUT0);
  assign is_in = (fcode == FN_INPUT) | (fcode == FN_PULSE) | (fcode == FN_CSENSE);
  // legality of a code on a pin
  assign legal = (avs_writedata_i[2:0] <= FN_CSENSE) & ~(od_pin & is_in)
                 & ((fcode != FN_SOC_PWM) | (fidx == 4'(PIN_GAUGE)))
                 & ((fcode != FN_PULSE) | (fidx == 4'(PIN_SPEED)))
                 & ((fcode != FN_CSENSE) | in_grp);

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      for (int i = 0; i < NPIN; i++)
        func[i] <= FN_NONE;
    end
    else if (fsel & legal)
    begin
      // sensor function spreads to all inputs
      if (fcode == FN_CSENSE)
      begin
        for (int i = PIN_INPUT0; i <= PIN_INPUT3; i++)
          func[i] <= FN_CSENSE;
      end
      // leaving sensor function clears the group
      else if (in_grp & (func[fidx] == FN_CSENSE))
      begin
        for (int i = PIN_INPUT0; i <= PIN_INPUT3; i++)
          func[i] <= FN_NONE;
        func[fidx] <= fcode;
      end
      else
        func[fidx] <= fcode;
    end
  end

  // refused assignment flag; a refusal in the clearing cycle still sets it
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      reject <= 1'b0;
    else if (fsel & ~legal)
      reject <= 1'b1;
    else if (wr_ctrl & mdata[CTRL_REJECT])
      reject <= 1'b0;
  end

  a_sense_group: assert property (@(posedge clk_i) disable iff (srst_i)
    (func[PIN_INPUT0] == FN_CSENSE) == (func[PIN_INPUT0 + 1] == FN_CSENSE)
    && (func[PIN_INPUT0] == FN_CSENSE) == (func[PIN_INPUT0 + 2] == FN_CSENSE)
    && (func[PIN_INPUT0] == FN_CSENSE) == (func[PIN_INPUT3] == FN_CSENSE))
    else $error("sensor group inconsistent");
  a_sense_leave: assert property (@(posedge clk_i) disable iff (srst_i)
    fsel && legal && in_grp && fcode != FN_CSENSE && func[fidx] == FN_CSENSE |=> !cs_on)
    else $error("sensor function not removed");

  for (genvar g = 0; g < NPIN; g++)
  begin : g_pin
    logic act, lvl;
    always_comb
    begin
      act = 1'b1;
      lvl = 1'b0;
      case (func[g])
        FN_OUT_OFF: lvl = 1'b0;
        FN_OUT_ON: lvl = 1'b1;
        FN_SOC_PWM: lvl = pwm_q;
        default: act = 1'b0;
      endcase
    end
    always_ff @(posedge clk_i)
    begin
      if (srst_i)
      begin
        pad_out_o[g] <= 1'b0;
        pad_oe_n_o[g] <= 1'b1;
      end
      else if (g <= PIN_CHARGER)
      begin
        // open drain only sinks; on means pulled low
        pad_out_o[g] <= 1'b0;
        pad_oe_n_o[g] <= ~(act & lvl);
      end
      else
      begin
        pad_out_o[g] <= lvl;
        pad_oe_n_o[g] <= ~act;
      end
    end
    if (g <= PIN_CHARGER)
    begin : g_od
      a_od_noinput: assert property (@(posedge clk_i) disable iff (srst_i)
        func[g] != FN_INPUT && func[g] != FN_PULSE && func[g] != FN_CSENSE)
        else $error("input function on open drain pin");
    end
    if (g != PIN_GAUGE)
    begin : g_npwm
      a_pwm_gauge: assert property (@(posedge clk_i) disable iff (srst_i) func[g] != FN_SOC_PWM)
        else $error("charge PWM on wrong pin");
    end
  end
endmodule
`default_nettype wire

//--- src/sgm_pkg.sv
// constants, codes and carrier types of the gauge and pin function block
package sgm_pkg;
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned GATE_MS = 1000;
  localparam int unsigned GATE_CYC = GATE_MS * (CLK_HZ / 1000);
  localparam int unsigned PWM_HZ = 1000;
  localparam int unsigned PWM_STEPS = 100;
  localparam int unsigned PWM_DIV = CLK_HZ / (PWM_HZ * PWM_STEPS);
  localparam int unsigned NPIN = 14;
  localparam int unsigned GAIN_SHIFT = 10;
  localparam logic [15:0] LO_LIMIT_RST = 16'h7000;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_SOC = 8'h04;
  localparam logic [7:0] OFS_CAL_LO = 8'h08;
  localparam logic [7:0] OFS_CAL_HI = 8'h0C;
  localparam logic [7:0] OFS_DEADZONE = 8'h10;
  localparam logic [7:0] OFS_DUTY_CFG = 8'h14;
  localparam logic [7:0] OFS_STORED_SOC = 8'h18;
  localparam logic [7:0] OFS_CURRENT = 8'h1C;
  localparam logic [7:0] OFS_PULSE_CNT = 8'h20;
  localparam logic [7:0] OFS_PULSE_FREQ = 8'h24;
  localparam logic [7:0] OFS_PIN_LEVEL = 8'h28;
  localparam logic [7:0] OFS_DUTY_NOW = 8'h2C;
  localparam logic [7:0] OFS_PIN_FUNC = 8'h40;
  // control register fields and the bit position of the duty maximum field
  localparam int unsigned CTRL_REVERSE = 0;
  localparam int unsigned CTRL_ZERO = 1;
  localparam int unsigned CTRL_LOAD = 2;
  localparam int unsigned CTRL_REJECT = 8;
  localparam int unsigned DUTY_MAX_LSB = 8;
  // reset values and full-scale percentage
  localparam logic [6:0] SOC_RST = 7'h00;
  localparam logic [6:0] PCT_FULL = 7'h64;
  localparam logic [15:0] CAL_RST = 16'h0400;
  localparam logic [15:0] DEADZONE_RST = 16'h0003;
  localparam logic [6:0] DUTY_MIN_RST = 7'h00;
  localparam logic [6:0] DUTY_MAX_RST = 7'h64;
  // pin indices: 0..4 open drain, 5..13 low power
  localparam int unsigned PIN_HEATER = 0;
  localparam int unsigned PIN_LOW_BATTERY = 1;
  localparam int unsigned PIN_BUZZER = 2;
  localparam int unsigned PIN_CHARGE_IND = 3;
  localparam int unsigned PIN_CHARGER = 4;
  localparam int unsigned PIN_FAST_CHARGE = 5;
  localparam int unsigned PIN_MAINS_SENSE = 6;
  localparam int unsigned PIN_IGNITION = 7;
  localparam int unsigned PIN_GAUGE = 8;
  localparam int unsigned PIN_SPEED = 9;
  localparam int unsigned PIN_INPUT0 = 10;
  localparam int unsigned PIN_INPUT3 = 13;
  typedef enum logic [2:0] {
    FN_NONE = 3'h0,
    FN_OUT_OFF = 3'h1,
    FN_OUT_ON = 3'h2,
    FN_INPUT = 3'h3,
    FN_SOC_PWM = 3'h4,
    FN_PULSE = 3'h5,
    FN_CSENSE = 3'h6
  } sgm_func_t;
  typedef struct packed {
    logic valid;
    logic signed [15:0] lo;
    logic signed [15:0] hi;
  } sgm_sensor_t;
endpackage

//--- verification/sgm_far_side.sv
// far-side model: current sensor, pin wiring with pull-ups, speed pulse source
`timescale 1ns/1ps
`default_nettype none
module sgm_far_side (
  input wire logic clk_i, // bench clock
  input wire logic [sgm_pkg::NPIN-1:0] ext_i, // levels of outside sources
  input wire logic [sgm_pkg::NPIN-1:0] pad_out_i, // block drive level
  input wire logic [sgm_pkg::NPIN-1:0] pad_oe_n_i, // block enable, low drives
  output var sgm_pkg::sgm_sensor_t sens_o, // converted sample
  output var logic [sgm_pkg::NPIN-1:0] pad_in_o // resolved pin levels
);
  import sgm_pkg::*;
  logic speed_lvl = 1'b0;
  initial
  begin
    sens_o = '0;
  end
  // released open-drain pins read high through their pull-ups
  always_comb
  begin
    for (int i = 0; i < NPIN; i++)
      pad_in_o[i] = !pad_oe_n_i[i] ? pad_out_i[i] : (i <= PIN_CHARGER) ? 1'b1 :
        (i == PIN_SPEED) ? speed_lvl : ext_i[i];
  end
  // the converter keeps its last sample on the lines, valid is a strobe
  task automatic sample(input logic signed [15:0] lo, input logic signed [15:0] hi);
    @(posedge clk_i);
    sens_o <= '{1'b1, lo, hi};
    @(posedge clk_i);
    sens_o.valid <= 1'b0;
  endtask
  // period of 8 cycles, 4 high
  task automatic pulses(input int n);
    repeat (n)
    begin
      @(posedge clk_i);
      speed_lvl <= 1'b1;
      repeat (4) @(posedge clk_i);
      speed_lvl <= 1'b0;
      repeat (3) @(posedge clk_i);
    end
  endtask
endmodule
`default_nettype wire

//--- verification/testbench.sv
// self-checking bench for the gauge and pin function block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import sgm_pkg::*;
  localparam int unsigned GATE = 200;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic [7:0] avs_address_i = '0;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [3:0] avs_byteenable_i = 4'hF;
  logic [31:0] avs_writedata_i = '0;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  sgm_sensor_t sens_i;
  logic [NPIN-1:0] pad_in_i;
  logic [NPIN-1:0] pad_out_o;
  logic [NPIN-1:0] pad_oe_n_o;
  logic [NPIN-1:0] ext = '0;
  logic [31:0] rd;
  int failures = 0;
  int samples_checked = 0;
  int rev = 0;
  int ofs = 0;
  int glo = 1024;
  int ghi = 1024;
  int dz = 3;
  int lo;
  int hi;
  int s;
  int mn;
  int hcnt;
  always #25 clk_i = ~clk_i;
  sgm_top #(.GATE_CYC(GATE)) u_sgm_top (.clk_i(clk_i), .srst_i(srst_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .sens_i(sens_i), .pad_in_i(pad_in_i), .pad_out_o(pad_out_o), .pad_oe_n_o(pad_oe_n_o));
  sgm_far_side u_sgm_far_side (.clk_i(clk_i), .ext_i(ext), .pad_out_i(pad_out_o), .pad_oe_n_i(pad_oe_n_o),
    .sens_o(sens_i), .pad_in_o(pad_in_i));
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected %s: expected %0h seen %0h", name, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("mismatches %0d, comparisons %0d", failures, samples_checked);
    if (failures == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // request held until waitrequest is sampled low, one idle edge after release
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= wr;
    avs_read_i <= !wr;
    do
    begin
      @(posedge clk_i);
      n++;
      if (n > 20)
      begin
        failures++;
        stop_test();
      end
    end
    while (avs_waitrequest_o !== 1'b0);
    rd = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rdchk(input string name, input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    check(name, rd, exp);
  endtask
  function automatic logic [7:0] fa(input int p);
    return OFS_PIN_FUNC + 8'(4 * p);
  endfunction
  task automatic refuse(input int p, input logic [2:0] c);
    wr(fa(p), 32'(c));
    rdchk("refused_func", fa(p), 32'h0); // code ignored
    rdchk("reject_flag", OFS_CTRL, 32'h100 | rev); // refusal flagged
    wr(OFS_CTRL, 32'h100 | rev);
  endtask
  function automatic int scaled(input int l, input int h);
    if (l > int'(LO_LIMIT_RST) || -l > int'(LO_LIMIT_RST))
      return (h * ghi) >>> GAIN_SHIFT;
    return (l * glo) >>> GAIN_SHIFT;
  endfunction
  function automatic logic [31:0] exp_cur(input int l, input int h);
    int d;
    d = scaled(l, h) - ofs;
    if (d <= dz && -d <= dz)
      d = 0;
    return 32'(rev ? -d : d);
  endfunction
  function automatic int exp_duty(input int lo_pct, input int hi_pct, input int sc);
    return lo_pct + (hi_pct - lo_pct) * sc / 100;
  endfunction
  initial
  begin
    #(60000 * 50);
    failures++;
    stop_test();
  end
  initial
  begin
    void'($urandom(94));
    ext <= 14'($urandom);
    repeat (2) @(posedge clk_i);
    srst_i <= 1'b0;
    @(posedge clk_i);
    rdchk("soc", OFS_SOC, 32'h0); // soc at reset
    rdchk("duty", OFS_DUTY_NOW, 32'h0); // duty at reset
    rdchk("cal", OFS_CAL_HI, 32'(CAL_RST)); // unity gain
    rdchk("deadzone", OFS_DEADZONE, 32'h3); // reset width
    rdchk("unmapped", 8'h30, 32'h0); // hole
    for (int p = 0; p <= PIN_CHARGER; p++)
    begin
      refuse(p, FN_INPUT); // open drain
      refuse(p, FN_CSENSE); // open drain
    end
    for (int p = PIN_FAST_CHARGE; p <= PIN_INPUT3; p++)
      if (p != PIN_GAUGE)
        refuse(p, FN_SOC_PWM); // gauge only
    for (int c = 1; c <= 3; c++)
    begin
      wr(fa(PIN_FAST_CHARGE), 32'(c));
      wr(fa(PIN_LOW_BATTERY), c == 3 ? 32'h1 : 32'(c));
      repeat (3) @(posedge clk_i);
      check("oe_lp", 32'(pad_oe_n_o[PIN_FAST_CHARGE]), 32'(c == 3)); // drive
      check("out_lp", 32'(pad_out_o[PIN_FAST_CHARGE]), 32'(c == 2)); // level
      check("oe_od", 32'(pad_oe_n_o[PIN_LOW_BATTERY]), 32'(c != 2)); // sink
    end
    wr(fa(PIN_MAINS_SENSE), 32'(FN_INPUT));
    repeat (4) @(posedge clk_i);
    xfer(1'b0, OFS_PIN_LEVEL, 32'h0);
    check("level", 32'(rd[PIN_MAINS_SENSE]), 32'(ext[PIN_MAINS_SENSE])); // sensed
    check("od_idle", 32'(rd[PIN_LOW_BATTERY]), 32'h1); // released
    mn = $urandom_range(0, 30);
    wr(OFS_DUTY_CFG, 32'((120 << 8) | mn));
    rdchk("duty_cfg", OFS_DUTY_CFG, 32'((100 << 8) | mn)); // clamp
    for (int k = 0; k < 6; k++)
    begin
      s = k == 0 ? 0 : k == 1 ? 120 : k == 2 ? 100 : $urandom_range(1, 99);
      wr(OFS_SOC, 32'(s));
      s = s > 100 ? 100 : s;
      repeat (2) @(posedge clk_i);
      rdchk("soc", OFS_SOC, 32'(s)); // written
      rdchk("duty", OFS_DUTY_NOW, 32'(exp_duty(mn, 100, s))); // mapping
    end
    s = $urandom_range(1, 99);
    wr(OFS_STORED_SOC, 32'(s));
    wr(OFS_CTRL, 32'h4);
    rdchk("loaded", OFS_SOC, 32'(s)); // stored value
    wr(OFS_DUTY_CFG, 32'((90 << 8) | 10));
    wr(OFS_SOC, 32'd50);
    wr(fa(PIN_GAUGE), 32'(FN_SOC_PWM));
    repeat (PWM_DIV * PWM_STEPS) @(posedge clk_i);
    hcnt = 0;
    repeat (PWM_DIV * PWM_STEPS)
    begin
      @(posedge clk_i);
      hcnt += pad_out_o[PIN_GAUGE];
    end
    check("pwm_high", 32'(hcnt), 32'(exp_duty(10, 90, 50) * PWM_DIV)); // gauge duty
    wr(fa(PIN_INPUT0 + 1), 32'(FN_CSENSE));
    for (int p = PIN_INPUT0; p <= PIN_INPUT3; p++)
      rdchk("csense", fa(p), 32'(FN_CSENSE)); // all four
    for (int k = 0; k < 14; k++)
    begin
      lo = k == 0 ? 3 : k == 1 ? -4 : k == 2 ? 32767 : $urandom_range(0, 4000) - 2000;
      hi = $urandom_range(0, 400) - 200;
      if (k == 3)
      begin
        glo = $urandom_range(256, 3072);
        ghi = $urandom_range(256, 3072);
        dz = $urandom_range(0, 10);
        wr(OFS_CAL_LO, 32'(glo));
        wr(OFS_CAL_HI, 32'(ghi));
        wr(OFS_DEADZONE, 32'(dz));
      end
      if (k == 9)
      begin
        rev = 1;
        wr(OFS_CTRL, 32'(rev));
      end
      u_sgm_far_side.sample(16'(lo), 16'(hi));
      repeat (2) @(posedge clk_i);
      rdchk("current", OFS_CURRENT, exp_cur(lo, hi)); // conditioning
      if (k == 6)
      begin
        wr(OFS_CTRL, 32'(rev | 2));
        ofs = scaled(lo, hi);
        u_sgm_far_side.sample(16'(lo), 16'(hi));
        repeat (2) @(posedge clk_i);
        rdchk("zeroed", OFS_CURRENT, 32'h0); // offset taken
      end
    end
    wr(fa(PIN_INPUT0 + 2), 32'(FN_INPUT));
    for (int p = PIN_INPUT0; p <= PIN_INPUT3; p++)
      rdchk("release", fa(p), p == PIN_INPUT0 + 2 ? 32'(FN_INPUT) : 32'(FN_NONE)); // removed
    u_sgm_far_side.sample(16'd100, 16'd0);
    repeat (2) @(posedge clk_i);
    rdchk("current_off", OFS_CURRENT, 32'h0); // needs all four
    wr(fa(PIN_SPEED), 32'(FN_PULSE));
    fork
      u_sgm_far_side.pulses(80);
      begin
        repeat (450) @(posedge clk_i);
        rdchk("freq", OFS_PULSE_FREQ, 32'(GATE / 8)); // rate
      end
    join
    repeat (6) @(posedge clk_i);
    rdchk("count", OFS_PULSE_CNT, 32'd80); // total
    stop_test();
  end
endmodule
`default_nettype wire
